// ---- hw/map_decoder_params.svh ----
`ifndef MAP_DECODER_PARAMS_SVH
`define MAP_DECODER_PARAMS_SVH

// register indices on the plain register port
`define REG_TERM_START 4'h0
`define REG_TERM_END 4'h1
`define REG_TERM_ATTR 4'h2
`define REG_TERM_SEL 4'h3
`define REG_CTRL 4'h4
`define REG_STATUS 4'h5
`define REG_MASK 4'h6
`define REG_LAST 4'h7
`define REG_ID 4'h8

// term attribute field positions
`define ATTR_FC_LO 0
`define ATTR_FC_HI 2
`define ATTR_FC_ANY 3
`define ATTR_TYPE_LO 4
`define ATTR_TYPE_HI 6
`define ATTR_INTERLOCK 7
`define ATTR_DUAL_PORT 8
`define ATTR_VALID 9
`define ATTR_W 10

// control register fields
`define CTRL_DEF_LO 0
`define CTRL_DEF_HI 2
`define CTRL_WRROM_BRK 3
`define CTRL_BOARD_BIG 4
`define CTRL_W 5

// status bits
`define ST_GUARD 0
`define ST_WRROM 1
`define ST_SYNC 2
`define ST_W 3

// block granularity: 512 bytes small board, 1024 bytes big board
`define BLK_SMALL_LSB 9
`define BLK_BIG_LSB 10

`define NUM_TERMS 8
`define ADDR_W 24
`define ID_VALUE 32'h00c0_ffee

`define CTRL_RESET 5'h02
`define ATTR_RESET 10'h000

`endif

// ---- hw/map_decoder_pkg.sv ----
package map_decoder_pkg;
    typedef enum logic [2:0] {
        MEM_EMU_RAM,
        MEM_EMU_ROM,
        MEM_TGT_RAM,
        MEM_TGT_ROM,
        MEM_GUARDED
    } mem_type_t;

    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_WAIT_BREAK,
        SYNC_COPY
    } sync_state_t;
endpackage

// ---- hw/emulation_memory_map_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "map_decoder_params.svh"

module emulation_memory_map_decoder (
    input wire logic mclk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    // emulation processor cycle, same clock
    input wire logic cyc_valid_i,
    input wire logic [`ADDR_W-1:0] cyc_addr_i,
    input wire logic [2:0] cyc_fc_i,
    input wire logic cyc_write_i,
    // pins from the target system
    input wire logic transfer_acknowledge_n_i,
    input wire logic emu_reset_i,
    input wire logic in_monitor_i,
    // classification of the cycle one cycle after it, the acknowledge one cycle later, and the copy strobe
    output logic dec_valid_o,
    output logic [2:0] dec_type_o,
    output logic [2:0] dec_term_o,
    output logic dec_hit_o,
    output logic dec_emu_sel_o,
    output logic dec_emu_wr_o,
    output logic dec_dual_port_o,
    output logic dec_use_target_ack_o,
    output logic break_o,
    output logic transfer_acknowledge_n_o,
    output logic sim_copy_o
);

    // ==========================================================
    // term storage
    logic [`ADDR_W-1:0] start_reg [`NUM_TERMS];
    logic [`ADDR_W-1:0] end_reg [`NUM_TERMS];
    logic [`ATTR_W-1:0] attr_reg [`NUM_TERMS];
    logic [2:0] sel_reg;
    logic [`CTRL_W-1:0] ctrl_reg;
    logic [`ST_W-1:0] status_reg;
    logic [`ST_W-1:0] status_next;
    logic [`ST_W-1:0] mask_reg;
    logic [3:0] last_reg;
    logic [31:0] rdata_reg;

    // ==========================================================
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [2:0] ack_sync_reg;
    logic [2:0] rst_sync_reg;
    logic [2:0] mon_sync_reg;
    logic ack_n_reg;
    logic emu_rst_reg;
    logic monitor_reg;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_sync_reg <= 3'h7;
            rst_sync_reg <= 3'h0;
            mon_sync_reg <= 3'h0;
            ack_n_reg <= 1'b1;
            emu_rst_reg <= 1'b0;
            monitor_reg <= 1'b0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[1:0], transfer_acknowledge_n_i};
            rst_sync_reg <= {rst_sync_reg[1:0], emu_reset_i};
            mon_sync_reg <= {mon_sync_reg[1:0], in_monitor_i};
            if (ack_sync_reg[1] == ack_sync_reg[2]) begin
                ack_n_reg <= ack_sync_reg[2];
            end
            if (rst_sync_reg[1] == rst_sync_reg[2]) begin
                emu_rst_reg <= rst_sync_reg[2];
            end
            if (mon_sync_reg[1] == mon_sync_reg[2]) begin
                monitor_reg <= mon_sync_reg[2];
            end
        end
    end

    // ==========================================================
    // term match, one generate loop over the eight terms
    logic [`NUM_TERMS-1:0] hit_vec;
    logic blk_big;
    assign blk_big = ctrl_reg[`CTRL_BOARD_BIG];

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_TERMS; gi++) begin : g_term
            logic [`ADDR_W-1:0] lo_addr;
            logic [`ADDR_W-1:0] hi_addr;
            logic fc_ok;
            logic emu_type;
            assign emu_type = (attr_reg[gi][`ATTR_TYPE_HI:`ATTR_TYPE_LO] == 3'(map_decoder_pkg::MEM_EMU_RAM))
                || (attr_reg[gi][`ATTR_TYPE_HI:`ATTR_TYPE_LO] == 3'(map_decoder_pkg::MEM_EMU_ROM));
            // emulation memory is granted in whole blocks, so the range is widened to block edges
            always_comb begin
                lo_addr = start_reg[gi];
                hi_addr = end_reg[gi];
                if (emu_type) begin
                    if (blk_big) begin
                        lo_addr[`BLK_BIG_LSB-1:0] = '0;
                        hi_addr[`BLK_BIG_LSB-1:0] = '1;
                    end else begin
                        lo_addr[`BLK_SMALL_LSB-1:0] = '0;
                        hi_addr[`BLK_SMALL_LSB-1:0] = '1;
                    end
                end
            end
            assign fc_ok = attr_reg[gi][`ATTR_FC_ANY]
                || (attr_reg[gi][`ATTR_FC_HI:`ATTR_FC_LO] == cyc_fc_i);
            assign hit_vec[gi] = attr_reg[gi][`ATTR_VALID] && fc_ok
                && (cyc_addr_i >= lo_addr) && (cyc_addr_i <= hi_addr);
        end
    endgenerate

    // ==========================================================
    // pick the lowest hitting term; with legal overlaps only one can hit
    logic any_hit;
    logic [2:0] hit_idx;
    logic [2:0] cur_type;
    logic [`ATTR_W-1:0] hit_attr;

    always_comb begin
        any_hit = 1'b0;
        hit_idx = 3'h0;
        for (int i = `NUM_TERMS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                any_hit = 1'b1;
                hit_idx = 3'(i);
            end
        end
        hit_attr = attr_reg[hit_idx];
        if (any_hit) begin
            cur_type = hit_attr[`ATTR_TYPE_HI:`ATTR_TYPE_LO];
        end else begin
            cur_type = ctrl_reg[`CTRL_DEF_HI:`CTRL_DEF_LO];
        end
    end

    // ==========================================================
    // memory type classes of the current cycle
    logic is_guard;
    logic is_rom;
    logic is_emu;
    logic guard_brk;
    logic rom_brk;
    assign is_guard = cur_type == 3'(map_decoder_pkg::MEM_GUARDED);
    assign is_rom = (cur_type == 3'(map_decoder_pkg::MEM_EMU_ROM))
        || (cur_type == 3'(map_decoder_pkg::MEM_TGT_ROM));
    assign is_emu = any_hit && ((cur_type == 3'(map_decoder_pkg::MEM_EMU_RAM))
        || (cur_type == 3'(map_decoder_pkg::MEM_EMU_ROM)));
    assign guard_brk = cyc_valid_i && is_guard;
    assign rom_brk = cyc_valid_i && cyc_write_i && is_rom && ctrl_reg[`CTRL_WRROM_BRK];

    // ==========================================================
    // decode outputs, registered
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dec_valid_o <= 1'b0;
            dec_type_o <= 3'h0;
            dec_term_o <= 3'h0;
            dec_hit_o <= 1'b0;
            dec_emu_sel_o <= 1'b0;
            dec_emu_wr_o <= 1'b0;
            dec_dual_port_o <= 1'b0;
            dec_use_target_ack_o <= 1'b0;
            break_o <= 1'b0;
        end else begin
            dec_valid_o <= cyc_valid_i;
            dec_type_o <= cur_type;
            dec_term_o <= hit_idx;
            dec_hit_o <= cyc_valid_i && any_hit;
            dec_emu_sel_o <= cyc_valid_i && is_emu;
            // rom-typed emulation memory still takes the write, break or not
            dec_emu_wr_o <= cyc_valid_i && is_emu && cyc_write_i;
            dec_dual_port_o <= cyc_valid_i && is_emu && hit_attr[`ATTR_DUAL_PORT];
            dec_use_target_ack_o <= cyc_valid_i && (!is_emu || hit_attr[`ATTR_INTERLOCK]);
            break_o <= guard_brk || rom_brk;
        end
    end

    // ==========================================================
    // acknowledge: emulator supplies it for plain emulation cycles, else target passes through
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            transfer_acknowledge_n_o <= 1'b1;
        end else if (dec_valid_o && dec_emu_sel_o && !dec_use_target_ack_o) begin
            transfer_acknowledge_n_o <= 1'b0;
        end else if (dec_valid_o && dec_use_target_ack_o) begin
            transfer_acknowledge_n_o <= ack_n_reg;
        end else begin
            transfer_acknowledge_n_o <= 1'b1;
        end
    end

    // ==========================================================
    // shadow-to-integration copy on the first monitor entry after reset
    map_decoder_pkg::sync_state_t sync_reg;
    logic sync_pulse;
    assign sync_pulse = (sync_reg == map_decoder_pkg::SYNC_COPY);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_reg <= map_decoder_pkg::SYNC_IDLE;
        end else begin
            unique case (sync_reg)
                map_decoder_pkg::SYNC_IDLE: begin
                    if (emu_rst_reg) begin
                        sync_reg <= map_decoder_pkg::SYNC_WAIT_BREAK;
                    end
                end
                map_decoder_pkg::SYNC_WAIT_BREAK: begin
                    if (!emu_rst_reg && monitor_reg) begin
                        sync_reg <= map_decoder_pkg::SYNC_COPY;
                    end
                end
                map_decoder_pkg::SYNC_COPY: begin
                    sync_reg <= map_decoder_pkg::SYNC_IDLE;
                end
                // the fourth code of the two-bit state is unused; fall back to idle
                default: begin
                    sync_reg <= map_decoder_pkg::SYNC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // copy strobe to the integration registers, one cycle long
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sim_copy_o <= 1'b0;
        end else begin
            sim_copy_o <= sync_pulse;
        end
    end

    // ==========================================================
    // register writes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < `NUM_TERMS; i++) begin
                start_reg[i] <= '0;
                end_reg[i] <= '0;
                attr_reg[i] <= `ATTR_RESET;
            end
            sel_reg <= 3'h0;
            ctrl_reg <= `CTRL_RESET;
            mask_reg <= '0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `REG_TERM_START: start_reg[sel_reg] <= reg_wdata_i[`ADDR_W-1:0];
                `REG_TERM_END: end_reg[sel_reg] <= reg_wdata_i[`ADDR_W-1:0];
                `REG_TERM_ATTR: attr_reg[sel_reg] <= reg_wdata_i[`ATTR_W-1:0];
                `REG_TERM_SEL: sel_reg <= reg_wdata_i[2:0];
                `REG_CTRL: ctrl_reg <= reg_wdata_i[`CTRL_W-1:0];
                `REG_MASK: mask_reg <= reg_wdata_i[`ST_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // sticky status; a set in the cycle of the clearing read wins
    always_comb begin
        status_next = status_reg;
        if (reg_rd_i && reg_addr_i == `REG_STATUS) begin
            status_next = '0;
        end
        if (guard_brk) begin
            status_next[`ST_GUARD] = 1'b1;
        end
        if (rom_brk) begin
            status_next[`ST_WRROM] = 1'b1;
        end
        if (sync_pulse) begin
            status_next[`ST_SYNC] = 1'b1;
        end
    end

    // ==========================================================
    // status, interrupt level and last hit capture
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_reg <= '0;
            last_reg <= 4'h0;
            irq_o <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_o <= |(status_next & mask_reg);
            if (cyc_valid_i) begin
                last_reg <= {any_hit, hit_idx};
            end
        end
    end

    // ==========================================================
    // read data, valid the cycle after the strobe only
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `REG_TERM_START: rdata_reg <= 32'(start_reg[sel_reg]);
                `REG_TERM_END: rdata_reg <= 32'(end_reg[sel_reg]);
                `REG_TERM_ATTR: rdata_reg <= 32'(attr_reg[sel_reg]);
                `REG_TERM_SEL: rdata_reg <= 32'(sel_reg);
                `REG_CTRL: rdata_reg <= 32'(ctrl_reg);
                `REG_STATUS: rdata_reg <= 32'(status_reg);
                `REG_MASK: rdata_reg <= 32'(mask_reg);
                `REG_LAST: rdata_reg <= 32'(last_reg);
                `REG_ID: rdata_reg <= `ID_VALUE; // value is arbitrary
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule

`default_nettype wire

// ---- sim/map_decoder_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========
// decode checker
module map_decoder_props (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic cyc_write_i,
    input wire logic dec_valid_o,
    input wire logic [2:0] dec_type_o,
    input wire logic dec_hit_o,
    input wire logic dec_emu_sel_o,
    input wire logic dec_emu_wr_o,
    input wire logic dec_dual_port_o,
    input wire logic dec_use_target_ack_o,
    input wire logic break_o,
    input wire logic transfer_acknowledge_n_o,
    input wire logic sim_copy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    guard_break_a: assert property (dec_valid_o && dec_type_o == 3'h4 |-> break_o)
        else $error("guarded cycle without break");
    rom_break_a: assert property (break_o |-> dec_valid_o &&
        (dec_type_o == 3'h4 || $past(cyc_write_i) && (dec_type_o == 3'h1 || dec_type_o == 3'h3)))
        else $error("break without cause");
    rom_store_a: assert property (dec_valid_o && dec_type_o == 3'h1 && $past(cyc_write_i) |-> dec_emu_wr_o)
        else $error("rom write not stored");
    emu_types_a: assert property (dec_valid_o |-> dec_emu_sel_o == (dec_type_o < 3'h2))
        else $error("routing disagrees with type");
    default_type_a: assert property (dec_valid_o && !dec_hit_o |-> dec_type_o inside {3'h2, 3'h3, 3'h4})
        else $error("bad default type");
    emu_ack_a: assert property (dec_valid_o && dec_emu_sel_o && !dec_use_target_ack_o |=> !transfer_acknowledge_n_o)
        else $error("emulator ack missing");
    tgt_ack_a: assert property (dec_valid_o && dec_type_o inside {3'h2, 3'h3} |-> dec_use_target_ack_o)
        else $error("target cycle not on target ack");
    dual_port_a: assert property (dec_dual_port_o |-> dec_valid_o && dec_emu_sel_o && dec_hit_o)
        else $error("dual port outside emulation term");
    copy_pulse_a: assert property (sim_copy_o |=> !sim_copy_o)
        else $error("copy pulse too long");
    cover property (break_o && dec_type_o == 3'h1);
    cover property (dec_dual_port_o);
    cover property (sim_copy_o);
endmodule

bind emulation_memory_map_decoder map_decoder_props u_props (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .cyc_write_i(cyc_write_i), .dec_valid_o(dec_valid_o), .dec_type_o(dec_type_o), .dec_hit_o(dec_hit_o),
    .dec_emu_sel_o(dec_emu_sel_o), .dec_emu_wr_o(dec_emu_wr_o), .dec_dual_port_o(dec_dual_port_o),
    .dec_use_target_ack_o(dec_use_target_ack_o), .break_o(break_o),
    .transfer_acknowledge_n_o(transfer_acknowledge_n_o), .sim_copy_o(sim_copy_o));
`default_nettype wire

// ---- sim/target_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========
// target system acknowledge
module target_bus_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic [3:0] delay_i,
    output logic transfer_acknowledge_n_o
);
    int cnt;
    // pulled-up pin: high whenever the target is not acknowledging
    // held low two cycles: a one-cycle pulse never gets through the emulator's pin filter
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            transfer_acknowledge_n_o <= 1'b1;
        end else begin
            transfer_acknowledge_n_o <= !(cnt == 1 || cnt == 2);
            if (req_i) begin
                cnt <= delay_i + 2;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "map_decoder_params.svh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value at %0t: %s", $time, m); end end
// ========
// bench
module tb_top;
    logic mclk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, cyc_valid_i = 0, cyc_write_i = 0;
    logic emu_reset_i = 0, in_monitor_i = 0, ack_n, irq_o, dec_valid_o, dec_hit_o, dec_emu_sel_o, dec_emu_wr_o;
    logic dec_dual_port_o, dec_use_target_ack_o, break_o, transfer_acknowledge_n_o, sim_copy_o;
    logic [3:0] reg_addr_i = 0, dly = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o;
    logic [23:0] cyc_addr_i = 0;
    logic [2:0] cyc_fc_i = 0, dec_type_o, dec_term_o;
    int mismatches = 0, n_checks = 0, cycles = 0, seed = 29, ctrl = 2, st = 0;
    int ts[8], te[8], ta[8], cfg[3] = '{2, 'h0b, 'h1c};
    logic [11:0] q[$];
    logic [11:0] e_dec;
    logic [11:0] got;
    logic ack_exp = 1'b1;
    logic syn = 1'b1;
    logic [2:0] sy = 3'h7;

    emulation_memory_map_decoder u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o), .cyc_valid_i(cyc_valid_i), .cyc_addr_i(cyc_addr_i), .cyc_fc_i(cyc_fc_i),
        .cyc_write_i(cyc_write_i), .transfer_acknowledge_n_i(ack_n), .emu_reset_i(emu_reset_i),
        .in_monitor_i(in_monitor_i), .dec_valid_o(dec_valid_o), .dec_type_o(dec_type_o), .dec_term_o(dec_term_o),
        .dec_hit_o(dec_hit_o), .dec_emu_sel_o(dec_emu_sel_o), .dec_emu_wr_o(dec_emu_wr_o),
        .dec_dual_port_o(dec_dual_port_o), .dec_use_target_ack_o(dec_use_target_ack_o), .break_o(break_o),
        .transfer_acknowledge_n_o(transfer_acknowledge_n_o), .sim_copy_o(sim_copy_o));
    target_bus_model u_tgt (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(dec_valid_o && dec_use_target_ack_o),
        .delay_i(dly), .transfer_acknowledge_n_o(ack_n));

    always #20 mclk_i = ~mclk_i;

    // lowest index wins; emulation ranges grow to whole blocks
    // only emulation memory without interlock is acknowledged by the emulator itself
    function automatic logic [11:0] model(int a, int fc, bit w);
        int t = ctrl & 7, k = 0, lo, hi, blk;
        bit h = 0;
        blk = ctrl[4] ? 1024 : 512;
        for (int i = 7; i >= 0; i--) begin
            lo = ts[i];
            hi = te[i];
            if (((ta[i] >> 4) & 7) < 2) begin
                lo = lo / blk * blk;
                hi = hi / blk * blk + blk - 1;
            end
            if (ta[i][9] && a >= lo && a <= hi && (ta[i][3] || (ta[i] & 7) == fc)) begin
                h = 1;
                k = i;
                t = (ta[i] >> 4) & 7;
            end
        end
        return {t == 4 || (ctrl[3] && w && (t == 1 || t == 3)), t > 1 || (h && ta[k][7]),
            t < 2 && h && ta[k][8], t < 2 && w, t < 2, h, k[2:0], t[2:0]};
    endfunction

    // target acknowledge as the emulator sees it behind its three-stage pin filter
    always @(posedge mclk_i) begin
        sy <= {sy[1:0], ack_n};
        if (sy[1] == sy[2]) begin
            syn <= sy[2];
        end
    end

    always @(negedge mclk_i) if (nrst_i) begin
        `CHK(transfer_acknowledge_n_o, ack_exp, "transfer acknowledge")
        ack_exp = 1'b1;
        if (dec_valid_o === 1'b1) begin
            if (q.size() == 0) `CHK(1'b0, 1'b1, "unexpected decode")
            else begin
                e_dec = q.pop_front();
                got = {break_o, dec_use_target_ack_o, dec_dual_port_o, dec_emu_wr_o, dec_emu_sel_o, dec_hit_o,
                    dec_hit_o ? dec_term_o : 3'h0, dec_type_o};
                `CHK(got[5:0], e_dec[5:0], "class")
                `CHK(got[11:6], e_dec[11:6], "route")
                ack_exp = e_dec[10] ? syn : !e_dec[7];
            end
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 0;
        @(negedge mclk_i);
        `CHK(reg_rdata_o, e, "register read")
    endtask

    task automatic term(input int i, s, e, at);
        ts[i] = s;
        te[i] = e;
        ta[i] = at;
        wr(`REG_TERM_SEL, i);
        wr(`REG_TERM_START, s);
        wr(`REG_TERM_END, e);
        wr(`REG_TERM_ATTR, at);
    endtask

    task automatic one(input int a, f, w, v);
        logic [11:0] e;
        @(posedge mclk_i);
        cyc_valid_i <= v[0];
        cyc_addr_i <= a[23:0];
        cyc_fc_i <= f[2:0];
        cyc_write_i <= w[0];
        e = model(a, f, w[0]);
        if (v[0]) begin
            q.push_back(e);
            st |= e[2:0] == 3'h4 ? 1 : e[11] ? 2 : 0;
        end
    endtask

    task automatic idle();
        one(0, 0, 0, 0);
        repeat (3) @(posedge mclk_i);
        `CHK(q.size(), 0, "decode missing")
    endtask

    task automatic conclude();
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // run is about 1350 cycles, so this only trips on a hang
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1;
        rd(`REG_CTRL, 32'h2);
        rd(`REG_STATUS, 32'h0);
        wr(4'h9, 32'hffff_ffff);
        rd(4'h9, 32'h0);
        rd(`REG_ID, `ID_VALUE);
        term(0, 'h1000, 'h11ff, 'h308);
        term(1, 'h2000, 'h23ff, 'h218);
        term(2, 'h3000, 'h30ff, 'h245);
        term(3, 'h3000, 'h30ff, 'h231);
        term(4, 'h4000, 'h43ff, 'h288);
        term(7, 'h5000, 'h5fff, 'h222);
        rd(`REG_TERM_START, 32'h5000);
        rd(`REG_TERM_ATTR, 32'h222);
        foreach (cfg[c]) begin
            ctrl = cfg[c];
            wr(`REG_CTRL, ctrl);
            dly <= 4'($random(seed));
            repeat (400) one((((($random(seed) & 7) << 12) + ($random(seed) & 'h7ff)) - 16) & 'hffffff,
                $random(seed) & 7, $random(seed) & 1, $random(seed) & 1);
            idle();
            rd(`REG_STATUS, st);
            st = 0;
        end
        wr(`REG_MASK, 32'h1);
        one('h3000, 5, 0, 1);
        idle();
        `CHK(irq_o, 1'b1, "interrupt not raised")
        rd(`REG_STATUS, 32'h1);
        `CHK(irq_o, 1'b0, "interrupt not cleared")
        rd(`REG_LAST, 32'ha);
        wr(`REG_MASK, 32'h2);
        one('h30ff, 5, 1, 1);
        idle();
        `CHK(irq_o, 1'b0, "masked interrupt")
        rd(`REG_STATUS, 32'h1);
        st = 0;
        @(posedge mclk_i);
        emu_reset_i <= 1;
        repeat (8) @(posedge mclk_i);
        emu_reset_i <= 0;
        in_monitor_i <= 1;
        for (int j = 0; j < 20 && sim_copy_o !== 1'b1; j++) @(negedge mclk_i);
        `CHK(sim_copy_o, 1'b1, "no shadow copy")
        repeat (2) @(posedge mclk_i);
        rd(`REG_STATUS, 32'h4);
        conclude();
    end
endmodule
`default_nettype wire
